// File: rtl/pqi_pkg.sv
// package for the queue setup and interrupt signalling block
// holds register offsets, field layouts, reset values and vector codes
// assumes a 32-bit apb slave with byte addresses on word boundaries
package pqi_pkg;

    // ******************************************************************
    // register offsets (byte addresses, one aligned word each)
    // ******************************************************************
    localparam logic [7:0] PICK_OFS    = 8'h00;
    localparam logic [7:0] LEN_OFS     = 8'h04;
    localparam logic [7:0] PAGE_OFS    = 8'h08;
    localparam logic [7:0] BASE_OFS    = 8'h0c;
    localparam logic [7:0] KICK_OFS    = 8'h10;
    localparam logic [7:0] CAUSE_OFS   = 8'h14;
    localparam logic [7:0] CFGVEC_OFS  = 8'h18;
    localparam logic [7:0] RINGVEC_OFS = 8'h1c;
    localparam logic [7:0] MODE_OFS    = 8'h20;

    // ******************************************************************
    // field positions
    // ******************************************************************
    localparam int CAUSE_QUEUE_BIT = 0;
    localparam int CAUSE_CFG_BIT   = 1;
    localparam int MODE_MSG_BIT    = 0;
    localparam int MODE_LEGACY_BIT = 1;

    // per-queue slot word: size, vector, page number
    localparam int SLOT_SIZE_LSB = 0;
    localparam int SLOT_VEC_LSB  = 16;
    localparam int SLOT_PAGE_LSB = 32;
    localparam int SLOT_W        = 64;

    // ******************************************************************
    // vector codes and ring alignment
    // ******************************************************************
    localparam logic [15:0] NO_VECTOR        = 16'hffff;
    localparam logic [15:0] VEC_LAST         = 16'h07ff;
    localparam int          MSG_VEC_W        = 11;
    localparam int          RING_ALIGN_BYTES = 4096;
    localparam int          PAGE_SHIFT       = $clog2(RING_ALIGN_BYTES);

    // ******************************************************************
    // reset values
    // ******************************************************************
    localparam logic [15:0] PICK_RST  = 16'h0000;
    localparam logic [1:0]  CAUSE_RST = 2'h0;
    localparam logic [1:0]  MODE_RST  = 2'h0;
    localparam logic [31:0] PAGE_RST  = 32'h0000_0000;

endpackage : pqi_pkg

// File: rtl/pqi_slot_mem.sv
// per-queue slot memory with one write port and two registered read ports
// assumes one clock; unwritten entries read as the default word
`timescale 1ns/1ps
module pqi_slot_mem #(
    parameter int               DEPTH   = 4,
    parameter int               WIDTH   = 64,
    parameter int               IW      = (DEPTH > 1) ? $clog2(DEPTH) : 1,
    parameter logic [WIDTH-1:0] DEFAULT = '0
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // write port
    input  wire logic             wr_en,
    input  wire logic [IW-1:0]    wr_idx,
    input  wire logic [WIDTH-1:0] wr_data,
    // read ports
    input  wire logic [IW-1:0]    rd_a_idx,
    output logic      [WIDTH-1:0] rd_a_data,
    input  wire logic [IW-1:0]    rd_b_idx,
    output logic      [WIDTH-1:0] rd_b_data
);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [DEPTH-1:0] written_reg;

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_idx] <= wr_data;
        end
    end

    // entries fall back to the default after reset without clearing the array
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            written_reg <= '0;
        end else if (wr_en) begin
            written_reg[wr_idx] <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_a_data <= DEFAULT;
            rd_b_data <= DEFAULT;
        end else begin
            rd_a_data <= written_reg[rd_a_idx] ? mem[rd_a_idx] : DEFAULT;
            rd_b_data <= written_reg[rd_b_idx] ? mem[rd_b_idx] : DEFAULT;
        end
    end

endmodule // pqi_slot_mem

// File: rtl/pqi_top.sv
// queue setup, ring kick and interrupt signalling over apb
// assumes one clock, events from the ring engine synchronous to pclk
`timescale 1ns/1ps
module pqi_top
    import pqi_pkg::*;
#(
    parameter int          NUM_QUEUES     = 4,
    parameter logic [15:0] QUEUE_MAX_SIZE = 16'h0100,
    parameter logic [15:0] MSG_TABLE_LAST = VEC_LAST
) (
    // clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // apb slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // ring engine events and lookup
    input  wire logic                 ring_event,
    input  wire logic [15:0]          ring_event_idx,
    input  wire logic                 config_event,
    output logic      [15:0]          ring_len_out,
    output logic      [43:0]          ring_base_out,
    // ring kick towards the engine
    output logic                      kick_valid,
    output logic      [15:0]          kick_queue,
    // interrupt delivery
    output logic                      irq_line,
    output logic                      msg_valid,
    output logic      [MSG_VEC_W-1:0] msg_vector
);

    // ******************************************************************
    // local types and constants
    // ******************************************************************
    localparam int          IW       = (NUM_QUEUES > 1) ? $clog2(NUM_QUEUES) : 1;
    localparam logic [15:0] NQ16     = 16'(NUM_QUEUES);
    localparam logic [63:0] SLOT_DEF = {PAGE_RST, NO_VECTOR, QUEUE_MAX_SIZE};

    // ******************************************************************
    // declarations
    // ******************************************************************
    logic [15:0]        pick_reg;
    logic [1:0]         mode_reg;
    logic [1:0]         flags_reg;
    logic [1:0]         flags_next;
    logic [15:0]        cfg_vec_reg;
    logic               pready_reg;
    logic               qev_d1_reg;
    logic               cfg_pend_reg;
    logic               cfg_pend_next;
    logic               access;
    logic               done;
    logic               wr_done;
    logic               rd_done;
    logic               addr_ok;
    logic               pick_exists;
    logic               ev_exists;
    logic               msg_en;
    logic               legacy;
    logic               q_set;
    logic               c_set;
    logic               q_send;
    logic               cause_rd;
    logic               mem_wr_en;
    logic [SLOT_W-1:0]  mem_wr_data;
    logic [SLOT_W-1:0]  rd_a_data;
    logic [SLOT_W-1:0]  rd_b_data;
    logic [15:0]        a_size;
    logic [15:0]        a_vec;
    logic [31:0]        a_page;
    logic [15:0]        b_size;
    logic [15:0]        b_vec;
    logic [31:0]        b_page;
    logic [31:0]        rdata_next;

    // ******************************************************************
    // bus phases and decode
    // ******************************************************************
    assign access      = psel & penable;
    assign done        = access & pready_reg;
    assign wr_done     = done & pwrite;
    assign rd_done     = done & ~pwrite;
    assign msg_en      = mode_reg[MODE_MSG_BIT];
    assign legacy      = mode_reg[MODE_LEGACY_BIT];
    assign pick_exists = pick_reg < NQ16;
    assign ev_exists   = ring_event_idx < NQ16;

    assign a_size = rd_a_data[SLOT_SIZE_LSB +: 16];
    assign a_vec  = rd_a_data[SLOT_VEC_LSB +: 16];
    assign a_page = rd_a_data[SLOT_PAGE_LSB +: 32];
    assign b_size = rd_b_data[SLOT_SIZE_LSB +: 16];
    assign b_vec  = rd_b_data[SLOT_VEC_LSB +: 16];
    assign b_page = rd_b_data[SLOT_PAGE_LSB +: 32];

    always_comb begin
        unique case (paddr)
            PICK_OFS, LEN_OFS, PAGE_OFS, BASE_OFS, KICK_OFS,
            CAUSE_OFS, CFGVEC_OFS, RINGVEC_OFS, MODE_OFS: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // mapping beyond the supported table fails and reads back unmapped
    function automatic logic [15:0] map_vec(input logic [15:0] v);
        map_vec = (v <= MSG_TABLE_LAST) ? v : NO_VECTOR;
    endfunction

    // one wait state so slot data of a just-changed pick has settled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
        end else begin
            pready_reg <= access & ~pready_reg;
        end
    end

    // ******************************************************************
    // control registers
    // ******************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pick_reg <= PICK_RST;
        end else if (wr_done && paddr == PICK_OFS) begin
            pick_reg <= pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= MODE_RST;
        end else if (wr_done && paddr == MODE_OFS) begin
            mode_reg <= pwdata[1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_vec_reg <= NO_VECTOR;
        end else if (wr_done && paddr == CFGVEC_OFS) begin
            cfg_vec_reg <= map_vec(pwdata[15:0]);
        end
    end

    // ******************************************************************
    // per-queue slots
    // ******************************************************************
    always_comb begin
        mem_wr_en   = 1'b0;
        mem_wr_data = rd_a_data;
        if (wr_done && pick_exists) begin
            unique case (paddr)
                LEN_OFS: begin
                    // legacy size is fixed at the reported value
                    if (!legacy && pwdata[15:0] != 16'h0000 && pwdata[15:0] <= QUEUE_MAX_SIZE) begin
                        mem_wr_en                       = 1'b1;
                        mem_wr_data[SLOT_SIZE_LSB +: 16] = pwdata[15:0];
                    end
                end
                PAGE_OFS: begin
                    mem_wr_en                        = 1'b1;
                    mem_wr_data[SLOT_PAGE_LSB +: 32] = pwdata;
                end
                RINGVEC_OFS: begin
                    mem_wr_en                       = 1'b1;
                    mem_wr_data[SLOT_VEC_LSB +: 16] = map_vec(pwdata[15:0]);
                end
                default: mem_wr_en = 1'b0;
            endcase
        end
    end

    pqi_slot_mem #(
        .DEPTH   (NUM_QUEUES),
        .WIDTH   (SLOT_W),
        .IW      (IW),
        .DEFAULT (SLOT_DEF)
    ) u_slots (
        .clk       (pclk),
        .rst_n     (presetn),
        .wr_en     (mem_wr_en),
        .wr_idx    (pick_reg[IW-1:0]),
        .wr_data   (mem_wr_data),
        .rd_a_idx  (pick_reg[IW-1:0]),
        .rd_a_data (rd_a_data),
        .rd_b_idx  (ring_event_idx[IW-1:0]),
        .rd_b_data (rd_b_data)
    );

    // ******************************************************************
    // read data
    // ******************************************************************
    always_comb begin
        rdata_next = 32'h0000_0000;
        unique case (paddr)
            PICK_OFS:    rdata_next = {16'h0000, pick_reg};
            LEN_OFS:     rdata_next = {16'h0000, pick_exists ? a_size : 16'h0000};
            PAGE_OFS:    rdata_next = a_page;
            BASE_OFS:    rdata_next = {a_page[31-PAGE_SHIFT:0], {PAGE_SHIFT{1'b0}}};
            CAUSE_OFS:   rdata_next = {30'h0, flags_reg};
            CFGVEC_OFS:  rdata_next = {16'h0000, cfg_vec_reg};
            RINGVEC_OFS: rdata_next = {16'h0000, pick_exists ? a_vec : NO_VECTOR};
            MODE_OFS:    rdata_next = {30'h0, mode_reg};
            default:     rdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= access & ~pready_reg;
            pslverr <= access & ~pready_reg & ~addr_ok;
            prdata  <= (access && !pready_reg && !pwrite) ? rdata_next : 32'h0000_0000;
        end
    end

    // ******************************************************************
    // ring kick
    // ******************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            kick_valid <= 1'b0;
            kick_queue <= 16'h0000;
        end else begin
            kick_valid <= wr_done && paddr == KICK_OFS;
            if (wr_done && paddr == KICK_OFS) begin
                kick_queue <= pwdata[15:0];
            end
        end
    end

    // ******************************************************************
    // line interrupt and cause flags
    // ******************************************************************
    assign q_set    = ring_event & ev_exists & ~msg_en;
    assign c_set    = config_event & ~msg_en;
    assign cause_rd = rd_done && paddr == CAUSE_OFS;

    // a set in the clearing cycle survives the clear
    always_comb begin
        flags_next                  = cause_rd ? CAUSE_RST : flags_reg;
        flags_next[CAUSE_QUEUE_BIT] = flags_next[CAUSE_QUEUE_BIT] | q_set;
        flags_next[CAUSE_CFG_BIT]   = flags_next[CAUSE_CFG_BIT] | c_set;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_reg <= CAUSE_RST;
            irq_line  <= 1'b0;
        end else begin
            flags_reg <= flags_next;
            irq_line  <= |flags_next;
        end
    end

    // ******************************************************************
    // message interrupts
    // ******************************************************************
    assign q_send = qev_d1_reg & msg_en & (b_vec != NO_VECTOR);

    // config message waits one cycle behind a queue message
    assign cfg_pend_next = msg_en & ((config_event & (cfg_vec_reg != NO_VECTOR)) | (cfg_pend_reg & q_send));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            qev_d1_reg   <= 1'b0;
            cfg_pend_reg <= 1'b0;
        end else begin
            qev_d1_reg   <= ring_event & ev_exists & msg_en;
            cfg_pend_reg <= cfg_pend_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            msg_valid  <= 1'b0;
            msg_vector <= '0;
        end else begin
            msg_valid  <= q_send | (cfg_pend_reg & msg_en);
            msg_vector <= q_send ? b_vec[MSG_VEC_W-1:0] : cfg_vec_reg[MSG_VEC_W-1:0];
        end
    end

    // ******************************************************************
    // ring lookup for the engine
    // ******************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ring_len_out  <= 16'h0000;
            ring_base_out <= 44'h0;
        end else begin
            ring_len_out  <= b_size;
            ring_base_out <= {b_page, {PAGE_SHIFT{1'b0}}};
        end
    end

    // ******************************************************************
    // assertions
    // ******************************************************************
    a_cause_clear_read: assert property (@(posedge pclk) disable iff (!presetn)
        (cause_rd && !q_set && !c_set) |=> (flags_reg == 2'h0))
        else $error("cause flags not cleared by read");

    a_line_follows_flags: assert property (@(posedge pclk) disable iff (!presetn)
        (flags_reg != 2'h0) |-> irq_line)
        else $error("line interrupt low while a cause bit is set");

    a_queue_sets_bit0: assert property (@(posedge pclk) disable iff (!presetn)
        q_set |=> (flags_reg[CAUSE_QUEUE_BIT] && irq_line))
        else $error("queue event did not set bit 0 and the line");

    a_config_sets_bit1: assert property (@(posedge pclk) disable iff (!presetn)
        c_set |=> (flags_reg[CAUSE_CFG_BIT] && irq_line))
        else $error("config change did not set bit 1 and the line");

    a_queue_msg_vector: assert property (@(posedge pclk) disable iff (!presetn)
        (ring_event && ev_exists && msg_en && !mem_wr_en) ##1 (msg_en && b_vec != NO_VECTOR)
            |=> (msg_valid && msg_vector == $past(b_vec[MSG_VEC_W-1:0])))
        else $error("queue message missing or wrong vector");

    a_config_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
        (!cfg_pend_reg && config_event && !ring_event && cfg_vec_reg == NO_VECTOR && !qev_d1_reg) |=> ##1 !msg_valid)
        else $error("message sent for unmapped config change");

    a_kick_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_done && paddr == KICK_OFS) |=> (kick_valid && kick_queue == $past(pwdata[15:0])))
        else $error("kick not reported with its queue index");

    a_len_missing_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (access && !pready_reg && !pwrite && paddr == LEN_OFS && !pick_exists) |=> (prdata == 32'h0))
        else $error("missing queue did not read length 0");

    a_legacy_len_fixed: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_done && paddr == LEN_OFS && legacy) |-> !mem_wr_en)
        else $error("ring length changed in legacy mode");

    a_bus_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
        (access && !pready_reg) |=> (pready && pready_reg))
        else $error("access phase not answered after one wait");

endmodule // pqi_top

// File: testbench/pqi_host.sv
// host driver side apb master used by the bench
// assumes pclk from the bench and a slave that answers with pready
`timescale 1ns/1ps
module pqi_host (
    // clock
    input  wire logic        pclk,
    // apb master
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic        pready
);
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
    end

    // one transfer; the request holds until pready is seen high at an edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule // pqi_host

// File: testbench/test_pci_queue_setup_and_irq_signalling.sv
// self-checking bench for the queue setup and interrupt block
// assumes pqi_host drives apb; results are matched against queued notes
`timescale 1ns/1ps
module test_pci_queue_setup_and_irq_signalling;
    import pqi_pkg::*;
    localparam logic [15:0] QUEUE_MAX_SIZE = 16'h0100;
    logic                 pclk;
    logic                 presetn;
    logic                 psel;
    logic                 penable;
    logic                 pwrite;
    logic [7:0]           paddr;
    logic [31:0]          pwdata;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    logic                 ring_event;
    logic [15:0]          ring_event_idx;
    logic                 config_event;
    logic [15:0]          ring_len_out;
    logic [43:0]          ring_base_out;
    logic                 kick_valid;
    logic [15:0]          kick_queue;
    logic                 irq_line;
    logic                 msg_valid;
    logic [MSG_VEC_W-1:0] msg_vector;
    logic [32:0]          rdq[$];
    logic [15:0]          kq[$];
    logic [10:0]          mq[$];
    logic [31:0]          seed;
    logic [31:0]          pg;
    logic [10:0]          v;
    int                   n_fail;
    int                   n_checks;

    pqi_top #(.QUEUE_MAX_SIZE(QUEUE_MAX_SIZE)) pqi_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready,
        .pslverr, .ring_event, .ring_event_idx, .config_event, .ring_len_out, .ring_base_out, .kick_valid,
        .kick_queue, .irq_line, .msg_valid, .msg_vector);
    pqi_host pqi_host_inst (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pready);

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic check(input string name, input logic [43:0] seen, input logic [43:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic final_report();
        if (n_fail == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        pqi_host_inst.xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        rdq.push_back(e);
        pqi_host_inst.xfer(1'b0, a, 32'h0);
    endtask
    task automatic ev(input logic r, input logic c, input logic [15:0] q);
        @(posedge pclk);
        ring_event     <= r;
        config_event   <= c;
        ring_event_idx <= q;
        @(posedge pclk);
        ring_event   <= 1'b0;
        config_event <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask

    // ******************************************************************
    // clock, watchdog and output monitor
    // ******************************************************************
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        final_report();
    end
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            check("read", {pslverr, prdata}, rdq.size() ? rdq.pop_front() : 'x);
        end
        if (kick_valid === 1'b1) check("kick", kick_queue, kq.size() ? kq.pop_front() : 'x);
        if (msg_valid === 1'b1) check("msg", msg_vector, mq.size() ? mq.pop_front() : 'x);
    end

    // ******************************************************************
    // main sequence
    // ******************************************************************
    initial begin
        presetn        = 1'b0;
        ring_event     = 1'b0;
        config_event   = 1'b0;
        ring_event_idx = 16'h0;
        n_fail         = 0;
        n_checks       = 0;
        seed           = 32'hccf2;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(PICK_OFS, 33'h0);
        rd(LEN_OFS, {17'h0, QUEUE_MAX_SIZE});
        rd(RINGVEC_OFS, {17'h0, NO_VECTOR});
        rd(CFGVEC_OFS, {17'h0, NO_VECTOR});
        rd(8'h24, {1'b1, 32'h0});
        wr(PICK_OFS, 32'h4);
        rd(LEN_OFS, 33'h0);
        wr(PICK_OFS, 32'h1);
        wr(LEN_OFS, 32'h40);
        wr(LEN_OFS, 32'h200);
        rd(LEN_OFS, 33'h40);
        seed = lfsr(seed);
        pg = seed;
        wr(PAGE_OFS, pg);
        rd(BASE_OFS, {1'b0, pg[19:0], 12'h0});
        ring_event_idx <= 16'h1;
        repeat (3) @(posedge pclk);
        check("base", ring_base_out, {pg, 12'h0});
        check("len", ring_len_out, 16'h40);
        wr(MODE_OFS, 32'h2);
        wr(LEN_OFS, 32'h10);
        rd(LEN_OFS, 33'h40);
        wr(MODE_OFS, 32'h0);
        repeat (2) begin
            seed = lfsr(seed);
            kq.push_back(seed[15:0]);
            wr(KICK_OFS, seed);
        end
        seed = lfsr(seed);
        v = seed[10:0];
        wr(RINGVEC_OFS, {21'h0, v});
        rd(RINGVEC_OFS, {22'h0, v});
        wr(PICK_OFS, 32'h2);
        wr(RINGVEC_OFS, 32'h800);
        rd(RINGVEC_OFS, {17'h0, NO_VECTOR});
        // line mode: flags accumulate until one read clears them
        ev(1'b1, 1'b0, 16'h1);
        check("irq", irq_line, 1'b1);
        ev(1'b0, 1'b1, 16'h1);
        rd(CAUSE_OFS, 33'h3);
        rd(CAUSE_OFS, 33'h0);
        check("irq", irq_line, 1'b0);
        // message mode: mapped vectors send, unmapped ones stay silent
        wr(MODE_OFS, 32'h1);
        seed = lfsr(seed);
        wr(CFGVEC_OFS, {21'h0, seed[10:0]});
        mq.push_back(v);
        ev(1'b1, 1'b0, 16'h1);
        mq.push_back(seed[10:0]);
        ev(1'b0, 1'b1, 16'h1);
        ev(1'b1, 1'b0, 16'h2);
        // both events in one cycle: queue message first, config message next
        mq.push_back(v);
        mq.push_back(seed[10:0]);
        ev(1'b1, 1'b1, 16'h1);
        wr(CFGVEC_OFS, {16'h0, NO_VECTOR});
        ev(1'b0, 1'b1, 16'h1);
        rd(CAUSE_OFS, 33'h0);
        check("irq", irq_line, 1'b0);
        // mid-run reset: every mapping returns to unmapped
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        wr(PICK_OFS, 32'h1);
        rd(RINGVEC_OFS, {17'h0, NO_VECTOR});
        rd(LEN_OFS, {17'h0, QUEUE_MAX_SIZE});
        rd(MODE_OFS, 33'h0);
        repeat (5) @(posedge pclk);
        check("left", rdq.size() + kq.size() + mq.size(), 44'h0);
        final_report();
    end
endmodule // test_pci_queue_setup_and_irq_signalling
